// file: include/flash_erase_consts.svh
// Constants for the program flash row erase sequencer.
// Assumes inclusion by bare name from the include folder.
`ifndef FLASH_ERASE_CONSTS_SVH
`define FLASH_ERASE_CONSTS_SVH

// -----------------------------------------------------------------
// Pointer and row geometry
// -----------------------------------------------------------------
`define PTR_WIDTH 22
`define ROW_LSB 6
`define ROW_MSB 21
`define ROW_WORDS 64
`define ROW_BYTES 128

// -----------------------------------------------------------------
// Control fields and unlock keys
// -----------------------------------------------------------------
`define REGION_PROGRAM_FLASH 2'h2
`define UNLOCK_KEY_FIRST 8'h55
`define UNLOCK_KEY_SECOND 8'hAA

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define ERASE_TIME_US 10
`define ERASE_CYCLES ((`ERASE_TIME_US * 1000) / `CLK_PERIOD_NS)

`endif

// file: include/flash_erase_pkg.sv
// Types shared by the row erase sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package flash_erase_pkg;

   // -----------------------------------------------------------------
   // Sequencer states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ERASE,
      ST_FINISH
   } erase_state_t;

   // Unlock key tracker states
   typedef enum logic [1:0] {
      UK_NONE,
      UK_FIRST,
      UK_ARMED
   } unlock_state_t;

endpackage : flash_erase_pkg

// file: rtl/erase_timer.sv
// Internal programming timer that measures the erase time.
// Assumes one start pulse per erase; restarts ignored while busy.
`include "flash_erase_consts.svh"

module erase_timer #(
   parameter int CYCLES = `ERASE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic abort,
   output logic busy,
   output logic done
);

   logic [31:0] count;

   // -----------------------------------------------------------------
   // Countdown
   // -----------------------------------------------------------------
   // Counts down once started; done pulses in the first cycle after busy drops, one cycle after count reaches zero
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         count <= 32'h0000_0000;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            busy <= 1'b0;
            count <= 32'h0000_0000;
         end else if (start && !busy) begin
            busy <= 1'b1;
            count <= 32'(CYCLES - 1);
         end else if (busy) begin
            if (count == 32'h0000_0000) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               count <= count - 32'h0000_0001;
            end
         end
      end
   end

endmodule : erase_timer

// file: rtl/program_flash_row_erase.sv
// Sequencer that erases one program flash row on software request.
// Assumes the processor core presents control writes as one-cycle
// strobes and the flash array reports protection and validity.
`include "flash_erase_consts.svh"

module program_flash_row_erase
   import flash_erase_pkg::*;
#(
   parameter int ERASE_CYCLES = `ERASE_CYCLES,
   parameter int PTR_W = `PTR_WIDTH
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [PTR_W-1:0] table_pointer,
   input wire logic [7:0] table_latch,
   input wire logic table_write_op,
   input wire logic unlock_key_wr,
   input wire logic [7:0] unlock_key_data,
   input wire logic ctrl_wr,
   input wire logic [1:0] ctrl_region,
   input wire logic ctrl_write_permit,
   input wire logic ctrl_erase_sel,
   input wire logic ctrl_go,
   input wire logic ctrl_error_wr,
   input wire logic ctrl_error_val,
   input wire logic done_flag_clr,
   input wire logic nvm_done_irq_enable,
   input wire logic row_protected,
   input wire logic addr_invalid,
   input wire logic erase_abort,
   output logic write_permit,
   output logic go,
   output logic operation_error,
   output logic nvm_done_flag,
   output logic nvm_done_irq,
   output logic cpu_stall,
   output logic flash_erase_en,
   output logic [PTR_W-1:0] flash_row_addr,
   output logic [7:0] holding_latch
);

   erase_state_t state;
   unlock_state_t unlock;
   logic [1:0] region;
   logic erase_sel;
   logic timer_busy;
   logic timer_done;
   logic timer_start;
   logic go_accept;
   logic go_fault;
   logic erase_ok;
   logic erase_fail;

   // Clears the low pointer bits so the address names a whole row
   function automatic logic [PTR_W-1:0] row_base(input logic [PTR_W-1:0] ptr);
      row_base = {ptr[PTR_W-1:`ROW_LSB], {`ROW_LSB{1'b0}}};
   endfunction : row_base

   // -----------------------------------------------------------------
   // Launch decode
   // -----------------------------------------------------------------
   // Go is honoured only when armed by the full key pair
   assign go_accept = ctrl_wr && ctrl_go && (unlock == UK_ARMED) && (state == ST_IDLE);
   // Go set with a bad or protected pointer is refused
   assign go_fault = ctrl_wr && ctrl_go && (addr_invalid || row_protected);
   // Only a program flash erase with permit runs; nothing else is offered
   assign erase_ok = go_accept && !go_fault && write_permit && erase_sel
                     && (region == `REGION_PROGRAM_FLASH);
   assign timer_start = erase_ok;
   assign erase_fail = (state == ST_ERASE) && erase_abort;

   // -----------------------------------------------------------------
   // Unlock key tracker
   // -----------------------------------------------------------------
   // Any other control write or wrong key breaks the sequence
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         unlock <= UK_NONE;
      end else if (unlock_key_wr) begin
         if (unlock_key_data == `UNLOCK_KEY_FIRST) begin
            unlock <= UK_FIRST;
         end else if (unlock_key_data == `UNLOCK_KEY_SECOND && unlock == UK_FIRST) begin
            unlock <= UK_ARMED;
         end else begin
            unlock <= UK_NONE;
         end
      end else if (ctrl_wr) begin
         unlock <= UK_NONE;
      end
   end

   // -----------------------------------------------------------------
   // Control fields
   // -----------------------------------------------------------------
   // Software fields; the erase itself never alters the permit bit
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         region <= 2'h0;
         erase_sel <= 1'b0;
         write_permit <= 1'b0;
      end else if (ctrl_wr && state == ST_IDLE) begin
         region <= ctrl_region;
         erase_sel <= ctrl_erase_sel;
         write_permit <= ctrl_write_permit;
      end
   end

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   // Runs one row erase and ends it on the timer or an abort
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         go <= 1'b0;
         flash_erase_en <= 1'b0;
         flash_row_addr <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               go <= 1'b0;
               if (erase_ok) begin
                  state <= ST_ERASE;
                  go <= 1'b1;
                  flash_erase_en <= 1'b1;
                  flash_row_addr <= row_base(table_pointer);
               end
            end
            ST_ERASE: begin
               if (erase_abort) begin
                  state <= ST_IDLE;
                  go <= 1'b0;
                  flash_erase_en <= 1'b0;
               end else if (timer_done) begin
                  state <= ST_FINISH;
                  flash_erase_en <= 1'b0;
               end
            end
            ST_FINISH: begin
               state <= ST_IDLE;
               go <= 1'b0;
            end
            default: begin
               state <= ST_IDLE;
               go <= 1'b0;
               flash_erase_en <= 1'b0;
            end
         endcase
      end
   end

   // Processor held for the whole erase, until the timer finishes or an abort ends it
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cpu_stall <= 1'b0;
      end else begin
         cpu_stall <= erase_ok || (state == ST_ERASE && !timer_done && !erase_abort);
      end
   end

   // -----------------------------------------------------------------
   // Status flags
   // -----------------------------------------------------------------
   // Error flag: hardware set wins over a software clear
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         operation_error <= 1'b0;
      end else if (go_fault || erase_fail) begin
         operation_error <= 1'b1;
      end else if (ctrl_error_wr) begin
         operation_error <= ctrl_error_val;
      end
   end

   // Done flag and its interrupt request; set wins over clear
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         nvm_done_flag <= 1'b0;
         nvm_done_irq <= 1'b0;
      end else begin
         if (state == ST_FINISH) begin
            nvm_done_flag <= 1'b1;
         end else if (done_flag_clr) begin
            nvm_done_flag <= 1'b0;
         end
         nvm_done_irq <= (nvm_done_flag || state == ST_FINISH) && nvm_done_irq_enable
                         && !(done_flag_clr && state != ST_FINISH);
      end
   end

   // -----------------------------------------------------------------
   // Holding latch
   // -----------------------------------------------------------------
   // Table write is a short write into the latch only; erase leaves it
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         holding_latch <= 8'h00;
      end else if (table_write_op) begin
         holding_latch <= table_latch;
      end
   end

   // -----------------------------------------------------------------
   // Programming timer
   // -----------------------------------------------------------------
   erase_timer #(
      .CYCLES(ERASE_CYCLES)
   ) u_timer (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .start(timer_start),
      .abort(erase_fail),
      .busy(timer_busy),
      .done(timer_done)
   );

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_row_aligned: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(flash_erase_en) |-> flash_row_addr[`ROW_LSB-1:0] == '0)
      else $error("erase row address not row aligned");
   a_go_needs_unlock: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (ctrl_wr && ctrl_go && unlock != UK_ARMED && state == ST_IDLE) |=> !go)
      else $error("go set without unlock");
   a_protect_no_erase: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (ctrl_wr && ctrl_go && row_protected) |=> (!flash_erase_en || $past(state) != ST_IDLE)
      && operation_error)
      else $error("protected row started or no error");
   a_invalid_error: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (ctrl_wr && ctrl_go && addr_invalid) |=> operation_error)
      else $error("invalid address not flagged");
   a_abort_error: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == ST_ERASE && erase_abort) |=> operation_error && !go)
      else $error("abort not flagged");
   a_finish_flags: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == ST_ERASE && timer_done && !erase_abort) |=> ##1 (!go && nvm_done_flag))
      else $error("finish did not clear go or set done");
   a_stall_erase: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == ST_ERASE && timer_busy) |-> cpu_stall)
      else $error("processor not stalled during erase");
   a_permit_kept: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state != ST_IDLE) |=> $stable(write_permit)
      && ($stable(holding_latch) || $past(table_write_op)))
      else $error("erase changed permit or latch");
   a_latch_short: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (table_write_op && state == ST_IDLE && !erase_ok) |=> !flash_erase_en)
      else $error("table write started programming");

endmodule : program_flash_row_erase

// file: verif/flash_array_model.sv
// Behavioural model of the program flash array behind the sequencer.
// Assumes the sequencer holds its erase strobe as a level per erase.
module flash_array_model #(
   parameter int PROT_ROW = 16'h0003,
   parameter int LIMIT_ROW = 16'h0100
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [21:0] table_pointer,
   input wire logic flash_erase_en,
   input wire logic [21:0] flash_row_addr,
   output logic row_protected,
   output logic addr_invalid,
   output int erase_count,
   output int erase_len,
   output logic [21:0] erased_addr
);
   timeunit 1ns;
   timeprecision 1ns;
   logic erase_q;
   int run;

   // -----------------------------------------------------------------
   // Row status seen by the sequencer for the current pointer
   // -----------------------------------------------------------------
   assign row_protected = (table_pointer[21:6] == PROT_ROW[15:0]);
   assign addr_invalid = (table_pointer[21:6] >= LIMIT_ROW[15:0]);

   // Count erases, measure strobe length, note the erased row
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         erase_q <= 1'b0;
         run <= 0;
         erase_count <= 0;
         erase_len <= 0;
         erased_addr <= '0;
      end else begin
         erase_q <= flash_erase_en;
         if (flash_erase_en) begin
            run <= run + 1;
            erased_addr <= flash_row_addr;
         end
         if (flash_erase_en && !erase_q) erase_count <= erase_count + 1;
         if (!flash_erase_en && erase_q) begin
            erase_len <= run;
            run <= 0;
         end
      end
   end
endmodule : flash_array_model

// file: verif/testbench.sv
// Self-checking bench for the program flash row erase sequencer.
// Assumes the flash array model answers row status combinationally.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int N = 5;
   logic clk_sys = 0, sys_rst = 1;
   logic [21:0] table_pointer = '0, flash_row_addr, erased_addr;
   logic [7:0] table_latch = '0, unlock_key_data = '0, holding_latch;
   logic table_write_op = 0, unlock_key_wr = 0, ctrl_wr = 0, ctrl_go = 0;
   logic ctrl_error_wr = 0, ctrl_error_val = 0, done_flag_clr = 0;
   logic nvm_done_irq_enable = 0, erase_abort = 0, row_protected, addr_invalid;
   logic write_permit, go, operation_error, nvm_done_flag, nvm_done_irq;
   logic cpu_stall, flash_erase_en;
   logic [1:0] ctrl_region = 2'h2;
   logic ctrl_write_permit = 1, ctrl_erase_sel = 1;
   int erase_count, erase_len, errors = 0, tests_run = 0, cycles = 0;

   program_flash_row_erase #(.ERASE_CYCLES(N)) program_flash_row_erase_i (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .table_pointer(table_pointer), .table_latch(table_latch),
      .table_write_op(table_write_op), .unlock_key_wr(unlock_key_wr),
      .unlock_key_data(unlock_key_data), .ctrl_wr(ctrl_wr), .ctrl_region(ctrl_region),
      .ctrl_write_permit(ctrl_write_permit), .ctrl_erase_sel(ctrl_erase_sel),
      .ctrl_go(ctrl_go),
      .ctrl_error_wr(ctrl_error_wr), .ctrl_error_val(ctrl_error_val),
      .done_flag_clr(done_flag_clr), .nvm_done_irq_enable(nvm_done_irq_enable),
      .row_protected(row_protected), .addr_invalid(addr_invalid),
      .erase_abort(erase_abort), .write_permit(write_permit), .go(go),
      .operation_error(operation_error), .nvm_done_flag(nvm_done_flag),
      .nvm_done_irq(nvm_done_irq), .cpu_stall(cpu_stall), .flash_erase_en(flash_erase_en),
      .flash_row_addr(flash_row_addr), .holding_latch(holding_latch));
   flash_array_model flash_array_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .table_pointer(table_pointer), .flash_erase_en(flash_erase_en),
      .flash_row_addr(flash_row_addr), .row_protected(row_protected),
      .addr_invalid(addr_invalid), .erase_count(erase_count), .erase_len(erase_len),
      .erased_addr(erased_addr));

   // -----------------------------------------------------------------
   // Clock, timeout and common tasks
   // -----------------------------------------------------------------
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tick(int n = 1);
      repeat (n) @(posedge clk_sys);
      #10;
   endtask : tick
   // Control write; software keeps region, permit and erase select set
   task automatic ctrl_write(logic go_v);
      ctrl_wr = 1;
      ctrl_go = go_v;
      tick();
      ctrl_wr = 0;
      ctrl_go = 0;
   endtask : ctrl_write
   task automatic keys(logic [7:0] k1, logic [7:0] k2);
      unlock_key_wr = 1;
      unlock_key_data = k1;
      tick();
      unlock_key_data = k2;
      tick();
      unlock_key_wr = 0;
   endtask : keys
   task automatic launch();
      ctrl_write(0);
      keys(8'h55, 8'hAA);
      ctrl_write(1);
   endtask : launch
   task automatic wait_idle();
      for (int i = 0; i < 4 * N && go !== 1'b0; i++) tick();
      tick(2);
   endtask : wait_idle
   task automatic clear_error();
      ctrl_error_wr = 1;
      tick();
      ctrl_error_wr = 0;
   endtask : clear_error

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_erase();
      table_pointer = 22'h00_0A7F;
      nvm_done_irq_enable = 1;
      launch();
      tick();
      check("stall", cpu_stall, 1);
      check("row", flash_row_addr, 22'h00_0A40);
      wait_idle();
      check("go", go, 0);
      check("done", nvm_done_flag, 1);
      check("irq", nvm_done_irq, 1);
      check("stall", cpu_stall, 0);
      check("len", erase_len, N + 1);
      check("count", erase_count, 1);
      check("erased", erased_addr, 22'h00_0A40);
      check("low", erased_addr[5:0], 6'h00);
      check("permit", write_permit, 1);
      check("latch", holding_latch, 8'hC3);
      check("err", operation_error, 0);
      done_flag_clr = 1;
      tick();
      done_flag_clr = 0;
      tick();
      check("done", nvm_done_flag, 0);
      check("irq", nvm_done_irq, 0);
   endtask : t_erase
   task automatic t_table_write();
      table_latch = 8'hC3;
      table_write_op = 1;
      tick();
      table_write_op = 0;
      tick(2);
      check("latch", holding_latch, 8'hC3);
      check("go", go, 0);
      check("count", erase_count, 0);
   endtask : t_table_write
   // Go after a broken key pair or an intervening control write is ignored
   task automatic t_refused();
      ctrl_write(1);
      keys(8'hAA, 8'h55);
      ctrl_write(1);
      keys(8'h55, 8'hAA);
      ctrl_write(0);
      tick();
      ctrl_write(1);
      tick(2);
      check("go", go, 0);
      check("count", erase_count, 1);
   endtask : t_refused
   // Launch with one stored field wrong: quietly ignored, no error
   task automatic t_setup(logic [1:0] region_v, logic permit_v, logic erase_v);
      ctrl_region = region_v;
      ctrl_write_permit = permit_v;
      ctrl_erase_sel = erase_v;
      launch();
      tick(2);
      check("go", go, 0);
      check("stall", cpu_stall, 0);
      check("count", erase_count, 1);
      check("err", operation_error, 0);
      ctrl_region = 2'h2;
      ctrl_write_permit = 1;
      ctrl_erase_sel = 1;
      tick();
   endtask : t_setup
   task automatic t_fault(logic [21:0] ptr, logic abort_it, int cnt);
      table_pointer = ptr;
      launch();
      tick(2);
      erase_abort = abort_it;
      tick();
      erase_abort = 0;
      wait_idle();
      check("go", go, 0);
      check("err", operation_error, 1);
      check("count", erase_count, cnt);
      clear_error();
      tick();
      check("err", operation_error, 0);
   endtask : t_fault

   initial begin
      tick(8);
      sys_rst = 0;
      tick();
      check("rst", {go, operation_error, nvm_done_flag, cpu_stall, flash_erase_en}, 0);
      t_table_write();
      t_erase();
      t_refused();
      t_setup(2'h1, 1, 1);
      t_setup(2'h2, 0, 1);
      t_setup(2'h2, 1, 0);
      t_fault(22'h00_00C5, 0, 1);
      t_fault(22'h3F_FFC0, 0, 1);
      t_fault(22'h00_0100, 1, 2);
      end_sim();
   end
endmodule : testbench
